// ---- rtl/smt_static_table.v ----
// Static station table with its indirect register window and the
// factory register block that follows it.
// Assumes a byte register port driven by the management port decoder on
// the system clock, and a dynamic table that answers in the request cycle.
`timescale 1ns/10ps
`include "smt_consts.vh"

module smt_static_table
(
  input  wire                 clk_sys,
  input  wire                 sys_rst,
  // Byte register port
  input  wire [7:0]           reg_addr,
  input  wire                 reg_wr,
  input  wire [7:0]           reg_wdata,
  input  wire                 reg_rd,
  output reg  [7:0]           reg_rdata,
  output reg                  reg_rvalid,
  // Destination lookup
  input  wire                 da_req,
  input  wire [47:0]          da_station,
  input  wire [3:0]           da_group,
  input  wire [1:0]           da_ingress,
  input  wire                 dyn_da_hit,
  input  wire [2:0]           dyn_da_ports,
  output wire                 fwd_valid,
  output wire                 fwd_hit,
  output wire                 fwd_static,
  output wire                 fwd_override,
  output wire [2:0]           fwd_ports,
  // Source lookup, forwarded to the dynamic table only
  input  wire                 sa_req,
  input  wire [47:0]          source_station,
  input  wire [3:0]           sa_group,
  output reg                  dyn_sa_req,
  output reg  [47:0]          dyn_sa_station,
  output reg  [3:0]           dyn_sa_group,
  // Factory test block
  input  wire [2:0]           factory_split_state,
  input  wire [5:0]           trim_status,
  input  wire [8:0]           queue_debug_bits,
  output wire [7:0]           factory_logic_ctrl,
  output wire [7:0]           factory_trim_a,
  output wire [7:0]           factory_trim_b,
  output wire [7:0]           factory_trim_c,
  output wire [7:0]           factory_trim_d,
  output wire [7:0]           factory_trim_e,
  output wire [1:0]           emitter_drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [7:0]                            access_ctrl;
  reg  [7:0]                            index_low;
  reg  [7:0]                            data7;
  reg  [7:0]                            data6;
  reg  [7:0]                            data5;
  reg  [7:0]                            data4;
  reg  [7:0]                            data3;
  reg  [7:0]                            data2;
  reg  [7:0]                            data1;
  reg  [7:0]                            data0;
  reg  [7:0]                            flog_ctrl;
  reg  [7:0]                            trim_a;
  reg  [7:0]                            trim_b;
  reg  [7:0]                            trim_c;
  reg  [7:0]                            trim_d;
  reg  [7:0]                            trim_e;
  reg  [1:0]                            emit_drv;
  reg  [7:0]                            next_rdata;

  wire                                  index_write;
  wire                                  sel_static;
  wire                                  index_in_range;
  wire                                  static_go;
  wire                                  static_rd;
  wire                                  static_wr;
  wire [`SMT_IDX_W-1:0]                 entry_index;
  wire [`SMT_ENTRY_W-1:0]               wr_entry;
  wire [`SMT_ENTRY_W-1:0]               rd_entry;
  wire [`SMT_ENTRIES*`SMT_ENTRY_W-1:0]  table_flat;

  ////////////////////////////////////////////////////////////////////////////
  // Access trigger decode

  // The trigger uses the index byte being written, not the old one
  assign index_write    = reg_wr && (reg_addr == `SMT_A_INDEX_LO);
  assign sel_static     = (access_ctrl[`SMT_C_SEL_HI:`SMT_C_SEL_LO]
                           == `SMT_SEL_STATIC);
  // Indexes past the eighth entry are ignored rather than aliased
  assign index_in_range = (access_ctrl[1:0] == 2'h0) &&
                          (reg_wdata[7:`SMT_IDX_W] == 5'h00);
  assign static_go      = index_write && sel_static && index_in_range;
  assign static_rd      = static_go && access_ctrl[`SMT_C_READ_BIT];
  assign static_wr      = static_go && !access_ctrl[`SMT_C_READ_BIT];
  assign entry_index    = reg_wdata[`SMT_IDX_W-1:0];

  // Entry image assembled from the data bytes, 0x7c on top
  assign wr_entry = {data7[1:0], data6, data5, data4,
                     data3, data2, data1, data0};

  ////////////////////////////////////////////////////////////////////////////
  // Table storage and lookup

  // Only this register path writes the store: no learning, no aging
  smt_entry_store u_store
  (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .wr_en      (static_wr),
    .wr_index   (entry_index),
    .wr_entry   (wr_entry),
    .rd_index   (entry_index),
    .rd_entry   (rd_entry),
    .table_flat (table_flat)
  );

  smt_lookup u_lookup
  (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .table_flat   (table_flat),
    .da_req       (da_req),
    .da_station   (da_station),
    .da_group     (da_group),
    .da_ingress   (da_ingress),
    .dyn_da_hit   (dyn_da_hit),
    .dyn_da_ports (dyn_da_ports),
    .fwd_valid    (fwd_valid),
    .fwd_hit      (fwd_hit),
    .fwd_static   (fwd_static),
    .fwd_override (fwd_override),
    .fwd_ports    (fwd_ports)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source lookups bypass the static table entirely

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dyn_sa_req     <= 1'b0;
      dyn_sa_station <= 48'h000000000000;
      dyn_sa_group   <= 4'h0;
    end
    else
    begin
      dyn_sa_req <= sa_req;
      if (sa_req)
      begin
        dyn_sa_station <= source_station;
        dyn_sa_group   <= sa_group;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and index registers

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      access_ctrl <= `SMT_RST_BYTE;
      index_low   <= `SMT_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `SMT_A_CTRL)
        access_ctrl <= reg_wdata;
      if (reg_addr == `SMT_A_INDEX_LO)
        index_low <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect data bytes; a table read loads them on the trigger edge so
  // the very next host access already sees the entry

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      data7 <= `SMT_RST_BYTE;
      data6 <= `SMT_RST_BYTE;
      data5 <= `SMT_RST_BYTE;
      data4 <= `SMT_RST_BYTE;
      data3 <= `SMT_RST_BYTE;
      data2 <= `SMT_RST_BYTE;
      data1 <= `SMT_RST_BYTE;
      data0 <= `SMT_RST_BYTE;
    end
    else if (static_rd)
    begin
      data7 <= {6'h00, rd_entry[57:56]};
      data6 <= rd_entry[55:48];
      data5 <= rd_entry[47:40];
      data4 <= rd_entry[39:32];
      data3 <= rd_entry[31:24];
      data2 <= rd_entry[23:16];
      data1 <= rd_entry[15:8];
      data0 <= rd_entry[7:0];
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SMT_A_DATA7: data7 <= reg_wdata;
        `SMT_A_DATA6: data6 <= reg_wdata;
        `SMT_A_DATA5: data5 <= reg_wdata;
        `SMT_A_DATA4: data4 <= reg_wdata;
        `SMT_A_DATA3: data3 <= reg_wdata;
        `SMT_A_DATA2: data2 <= reg_wdata;
        `SMT_A_DATA1: data1 <= reg_wdata;
        `SMT_A_DATA0: data0 <= reg_wdata;
        default:      data0 <= data0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Factory test registers; writable, but software should leave them

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      flog_ctrl <= `SMT_RST_FLOG_CTRL;
      trim_a    <= `SMT_RST_BYTE;
      trim_b    <= `SMT_RST_BYTE;
      trim_c    <= `SMT_RST_BYTE;
      trim_d    <= `SMT_RST_BYTE;
      trim_e    <= `SMT_RST_TRIM_E;
      emit_drv  <= 2'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SMT_A_FLOG_CTRL: flog_ctrl <= reg_wdata;
        `SMT_A_TRIM_A:    trim_a    <= reg_wdata;
        `SMT_A_TRIM_B:    trim_b    <= reg_wdata;
        `SMT_A_TRIM_C:    trim_c    <= reg_wdata;
        `SMT_A_TRIM_D:    trim_d    <= reg_wdata;
        `SMT_A_EMIT_STAT: emit_drv  <= reg_wdata[7:6];
        `SMT_A_TRIM_E:    trim_e    <= reg_wdata;
        default:          trim_e    <= trim_e;
      endcase
    end
  end

  assign factory_logic_ctrl = flog_ctrl;
  assign factory_trim_a     = trim_a;
  assign factory_trim_b     = trim_b;
  assign factory_trim_c     = trim_c;
  assign factory_trim_d     = trim_d;
  assign factory_trim_e     = trim_e;
  assign emitter_drive      = emit_drv;

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped addresses read as zero

  always @*
  begin
    case (reg_addr)
      `SMT_A_CTRL:      next_rdata = access_ctrl;
      `SMT_A_INDEX_LO:  next_rdata = index_low;
      // Static reads never leave a read pending, and bits 66:64 are zero
      `SMT_A_DATA8:     next_rdata = 8'h00;
      `SMT_A_DATA7:     next_rdata = data7;
      `SMT_A_DATA6:     next_rdata = data6;
      `SMT_A_DATA5:     next_rdata = data5;
      `SMT_A_DATA4:     next_rdata = data4;
      `SMT_A_DATA3:     next_rdata = data3;
      `SMT_A_DATA2:     next_rdata = data2;
      `SMT_A_DATA1:     next_rdata = data1;
      `SMT_A_DATA0:     next_rdata = data0;
      `SMT_A_FLOG_STAT: next_rdata = {5'h00, factory_split_state};
      `SMT_A_FLOG_CTRL: next_rdata = flog_ctrl;
      `SMT_A_TRIM_A:    next_rdata = trim_a;
      `SMT_A_TRIM_B:    next_rdata = trim_b;
      `SMT_A_TRIM_C:    next_rdata = trim_c;
      `SMT_A_TRIM_D:    next_rdata = trim_d;
      `SMT_A_EMIT_STAT: next_rdata = {emit_drv, trim_status};
      `SMT_A_TRIM_E:    next_rdata = trim_e;
      `SMT_A_QDBG_LO:   next_rdata = queue_debug_bits[7:0];
      `SMT_A_QDBG_HI:   next_rdata = {7'h00, queue_debug_bits[8]};
      default:          next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

endmodule // smt_static_table

// ---- inc/smt_consts.vh ----
// Constants for the static station table and its indirect register window.
// Assumes byte-wide registers addressed by an 8-bit register number.
//
// Contract
// - Destination lookup searches static and dynamic tables
// - Source lookups use only the dynamic table
// - Static hit overrides dynamic destination result
// - Aging never touches static entries
// - Eight entries, 58 bits, address in 47:0
// - Bits 57:54 filter group id, reset zero
// - Bit 53 adds group id to match
// - Bit 52 overrides disabled port settings
// - Bit 51 valid; invalid entries are absent
// - Bits 50:48 port mask; 111 excludes ingress
// - Data bytes 0x7f..0x83 read/write, reset zero
// - 0x7c holds bits 57:56, then lower bytes
// - Write to 0x7a starts access; bit4 reads
// - Table select 00 picks static table
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH

`define SMT_ENTRIES        8
`define SMT_ENTRY_W        58
`define SMT_IDX_W          3

`define SMT_F_GROUP_HI     57
`define SMT_F_GROUP_LO     54
`define SMT_F_USE_GROUP    53
`define SMT_F_OVERRIDE     52
`define SMT_F_VALID        51
`define SMT_F_PORTS_HI     50
`define SMT_F_PORTS_LO     48
`define SMT_F_STATION_HI   47
`define SMT_PORTS_ALL      3'h7

`define SMT_A_CTRL         8'h79
`define SMT_A_INDEX_LO     8'h7a
`define SMT_A_DATA8        8'h7b
`define SMT_A_DATA7        8'h7c
`define SMT_A_DATA6        8'h7d
`define SMT_A_DATA5        8'h7e
`define SMT_A_DATA4        8'h7f
`define SMT_A_DATA3        8'h80
`define SMT_A_DATA2        8'h81
`define SMT_A_DATA1        8'h82
`define SMT_A_DATA0        8'h83
`define SMT_A_FLOG_STAT    8'h84
`define SMT_A_FLOG_CTRL    8'h85
`define SMT_A_TRIM_A       8'h86
`define SMT_A_TRIM_B       8'h87
`define SMT_A_TRIM_C       8'h88
`define SMT_A_TRIM_D       8'h89
`define SMT_A_EMIT_STAT    8'h8a
`define SMT_A_TRIM_E       8'h8b
`define SMT_A_QDBG_LO      8'h8c
`define SMT_A_QDBG_HI      8'h8d

`define SMT_C_READ_BIT     4
`define SMT_C_SEL_HI       3
`define SMT_C_SEL_LO       2
`define SMT_SEL_STATIC     2'h0

`define SMT_RST_BYTE       8'h00
`define SMT_RST_FLOG_CTRL  8'h3f
`define SMT_RST_TRIM_E     8'h40

`endif

// ---- rtl/smt_entry_store.v ----
// Eight-entry static station table storage.
// Assumes one writer (the host register block) on the system clock.
`timescale 1ns/10ps
`include "smt_consts.vh"

module smt_entry_store
(
  input  wire                                      clk_sys,
  input  wire                                      sys_rst,
  input  wire                                      wr_en,
  input  wire [`SMT_IDX_W-1:0]                     wr_index,
  input  wire [`SMT_ENTRY_W-1:0]                   wr_entry,
  input  wire [`SMT_IDX_W-1:0]                     rd_index,
  output wire [`SMT_ENTRY_W-1:0]                   rd_entry,
  output wire [`SMT_ENTRIES*`SMT_ENTRY_W-1:0]      table_flat
);

  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // Whole entry loads on one edge, so lookups never see a half entry
  generate
    for (g = 0; g < `SMT_ENTRIES; g = g + 1)
    begin : g_entry
      reg [`SMT_ENTRY_W-1:0] entry;
      always @(posedge clk_sys)
      begin
        if (sys_rst)
          entry <= {`SMT_ENTRY_W{1'b0}};
        else if (wr_en && (wr_index == g))
          entry <= wr_entry;
      end
      assign table_flat[g*`SMT_ENTRY_W +: `SMT_ENTRY_W] = entry;
    end
  endgenerate

  assign rd_entry = table_flat[rd_index*`SMT_ENTRY_W +: `SMT_ENTRY_W];

endmodule // smt_entry_store

// ---- rtl/smt_lookup.v ----
// Destination lookup against the static table, merged with the dynamic
// table's answer. Assumes the dynamic answer arrives with the request.
`timescale 1ns/10ps
`include "smt_consts.vh"

module smt_lookup
(
  input  wire                                      clk_sys,
  input  wire                                      sys_rst,
  input  wire [`SMT_ENTRIES*`SMT_ENTRY_W-1:0]      table_flat,
  input  wire                                      da_req,
  input  wire [47:0]                               da_station,
  input  wire [3:0]                                da_group,
  input  wire [1:0]                                da_ingress,
  input  wire                                      dyn_da_hit,
  input  wire [2:0]                                dyn_da_ports,
  output reg                                       fwd_valid,
  output reg                                       fwd_hit,
  output reg                                       fwd_static,
  output reg                                       fwd_override,
  output reg  [2:0]                                fwd_ports
);

  wire [`SMT_ENTRIES-1:0] hit;
  reg  [`SMT_ENTRY_W-1:0] sel;
  reg                     any_hit;
  reg  [2:0]              ingress_mask;
  reg  [2:0]              static_ports;
  integer                 i;
  genvar                  g;

  generate
    for (g = 0; g < `SMT_ENTRIES; g = g + 1)
    begin : g_match
      wire [`SMT_ENTRY_W-1:0] e = table_flat[g*`SMT_ENTRY_W +: `SMT_ENTRY_W];
      assign hit[g] = e[`SMT_F_VALID] &&
        (e[`SMT_F_STATION_HI:0] == da_station) &&
        (!e[`SMT_F_USE_GROUP] ||
         (e[`SMT_F_GROUP_HI:`SMT_F_GROUP_LO] == da_group));
    end
  endgenerate

  // Lowest index wins if the host loaded duplicates
  always @*
  begin
    sel     = {`SMT_ENTRY_W{1'b0}};
    any_hit = 1'b0;
    for (i = `SMT_ENTRIES - 1; i >= 0; i = i - 1)
    begin
      if (hit[i])
      begin
        sel     = table_flat[i*`SMT_ENTRY_W +: `SMT_ENTRY_W];
        any_hit = 1'b1;
      end
    end
  end

  always @*
  begin
    case (da_ingress)
      2'h0:    ingress_mask = 3'h1;
      2'h1:    ingress_mask = 3'h2;
      2'h2:    ingress_mask = 3'h4;
      default: ingress_mask = 3'h0;
    endcase
    static_ports = sel[`SMT_F_PORTS_HI:`SMT_F_PORTS_LO];
    if (static_ports == `SMT_PORTS_ALL)
      static_ports = `SMT_PORTS_ALL & ~ingress_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Both tables are consulted; static answer takes precedence
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      fwd_valid    <= 1'b0;
      fwd_hit      <= 1'b0;
      fwd_static   <= 1'b0;
      fwd_override <= 1'b0;
      fwd_ports    <= 3'h0;
    end
    else
    begin
      fwd_valid <= da_req;
      if (da_req)
      begin
        if (any_hit)
        begin
          fwd_hit      <= 1'b1;
          fwd_static   <= 1'b1;
          fwd_override <= sel[`SMT_F_OVERRIDE];
          fwd_ports    <= static_ports;
        end
        else
        begin
          fwd_hit      <= dyn_da_hit;
          fwd_static   <= 1'b0;
          fwd_override <= 1'b0;
          fwd_ports    <= dyn_da_hit ? dyn_da_ports : 3'h0;
        end
      end
    end
  end

endmodule // smt_lookup

// ---- verif/smt_host_model.sv ----
// Host processor model on the byte register port.
// Assumes strobes are sampled on the rising edge of clk_sys.
`timescale 1ns/10ps
module smt_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  int late = 0;
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Factory registers are never written from here
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Released bus shows no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(negedge clk_sys);
      n++;
    end
    d = reg_rdata;
    if (n == 4)
      late++;
  endtask
  task automatic wr_entry(input logic [2:0] i, input logic [57:0] e);
    logic [63:0] v;
    v = {6'h00, e};
    for (int k = 0; k < 8; k++)
      wr(8'h7c + 8'(k), v[63-8*k -: 8]);
    wr(8'h79, 8'h00);
    wr(8'h7a, {5'h00, i});
  endtask
  task automatic rd_entry(input logic [2:0] i, output logic [63:0] v);
    logic [7:0] b;
    wr(8'h79, 8'h10);
    wr(8'h7a, {5'h00, i});
    for (int k = 0; k < 8; k++)
    begin
      rd(8'h7c + 8'(k), b);
      v[63-8*k -: 8] = b;
    end
  endtask
endmodule // smt_host_model

// ---- verif/smt_static_table_props.sv ----
// Port checker for the static station table block.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/10ps
module smt_checker
(
  input wire       clk_sys,
  input wire       sys_rst,
  input wire       reg_rd,
  input wire       reg_rvalid,
  input wire       da_req,
  input wire       dyn_da_hit,
  input wire [2:0] dyn_da_ports,
  input wire       fwd_valid,
  input wire       fwd_hit,
  input wire       fwd_static,
  input wire [2:0] fwd_ports,
  input wire       sa_req,
  input wire [47:0] source_station,
  input wire [3:0] sa_group,
  input wire       dyn_sa_req,
  input wire [47:0] dyn_sa_station,
  input wire [3:0] dyn_sa_group
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered in one cycle");
  property p_rd_cause;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read valid without a read");
  property p_da_answer;
    da_req |=> fwd_valid;
  endproperty
  a_da_answer: assert property (p_da_answer)
    else $error("lookup not answered in one cycle");
  property p_da_cause;
    fwd_valid |-> $past(da_req);
  endproperty
  a_da_cause: assert property (p_da_cause)
    else $error("lookup result without a request");
  property p_dyn_path;
    fwd_valid && !fwd_static |-> fwd_hit == $past(dyn_da_hit) &&
      fwd_ports == ($past(dyn_da_hit) ? $past(dyn_da_ports) : 3'h0);
  endproperty
  a_dyn_path: assert property (p_dyn_path)
    else $error("dynamic result not passed on");
  property p_hold;
    !da_req |=> $stable(fwd_ports) && $stable(fwd_hit);
  endproperty
  a_hold: assert property (p_hold)
    else $error("lookup result changed without request");
  property p_sa_fwd;
    sa_req |=> dyn_sa_req && dyn_sa_station == $past(source_station)
      && dyn_sa_group == $past(sa_group);
  endproperty
  a_sa_fwd: assert property (p_sa_fwd)
    else $error("source lookup not passed to dynamic table");
  property p_sa_cause;
    dyn_sa_req |-> $past(sa_req);
  endproperty
  a_sa_cause: assert property (p_sa_cause)
    else $error("dynamic source request without cause");
  property p_sa_static;
    sa_req && !da_req |=> !fwd_valid;
  endproperty
  a_sa_static: assert property (p_sa_static)
    else $error("source lookup produced a static result");
endmodule // smt_checker

// ---- verif/tb.sv ----
// Self-checking bench for the static station table block.
// Assumes the host model drives the register port on falling edges.
`timescale 1ns/10ps
module tb;
  logic clk_sys, sys_rst, da_req, dyn_da_hit, sa_req, reg_wr, reg_rd;
  logic fwd_valid, fwd_hit, fwd_static, fwd_override, reg_rvalid;
  logic dyn_sa_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, factory_logic_ctrl;
  logic [7:0] factory_trim_e, factory_trim_a, factory_trim_b;
  logic [7:0] factory_trim_c, factory_trim_d;
  logic [1:0] emitter_drive;
  logic [47:0] da_station, source_station, dyn_sa_station;
  logic [3:0] da_group, sa_group, dyn_sa_group;
  logic [1:0] da_ingress;
  logic [2:0] dyn_da_ports, fwd_ports;
  int n_fail = 0;
  int check_count = 0;
  localparam logic [57:0] E1 = {10'h15f, 48'h0a1b2c3d4e5f};
  localparam logic [57:0] E2 = {10'h269, 48'h111111111111};
  localparam logic [57:0] E3 = {10'h261, 48'h111111111111};
  smt_static_table i_smt_static_table (.clk_sys, .sys_rst, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .da_req,
    .da_station, .da_group, .da_ingress, .dyn_da_hit, .dyn_da_ports,
    .fwd_valid, .fwd_hit, .fwd_static, .fwd_override, .fwd_ports,
    .sa_req, .source_station, .sa_group, .dyn_sa_req, .dyn_sa_station,
    .dyn_sa_group, .factory_split_state(3'h5), .trim_status(6'h2a),
    .queue_debug_bits(9'h1c3), .factory_logic_ctrl, .factory_trim_a,
    .factory_trim_b, .factory_trim_c, .factory_trim_d,
    .factory_trim_e, .emitter_drive);
  smt_host_model host (.clk_sys, .reg_rdata, .reg_rvalid, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd);
  ////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
    if (host.late != 0)
    begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic ent(input logic [2:0] i, input logic [57:0] exp);
    logic [63:0] v;
    host.rd_entry(i, v);
    chk(v, {6'h00, exp});
  endtask
  // k is group and station, dy is hit and ports, ex is hit/static/ovr/ports
  task automatic look(input logic [51:0] k, input logic [1:0] ing,
                      input logic [3:0] dy, input logic [5:0] ex);
    @(negedge clk_sys);
    {da_group, da_station} = k;
    da_ingress = ing;
    {dyn_da_hit, dyn_da_ports} = dy;
    da_req = 1'b1;
    @(negedge clk_sys);
    da_req = 1'b0;
    dyn_da_hit = 1'b0;
    chk({fwd_valid, fwd_hit, fwd_static, fwd_override, fwd_ports},
        {1'b1, ex});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    logic [15:0] tv [18] = '{16'h7c00, 16'h7d00, 16'h7e00, 16'h7f00,
      16'h8000, 16'h8100, 16'h8200, 16'h8300, 16'h7b00, 16'h853f,
      16'h8b40, 16'h8405, 16'h8a2a, 16'h8cc3, 16'h8600, 16'h8700,
      16'h8800, 16'h8900};
    foreach (tv[i])
      rdc(tv[i][15:8], tv[i][7:0]);
    rdc(8'h8d, 8'h01);
    rdc(8'h10, 8'h00);
    chk({factory_logic_ctrl, factory_trim_e}, 16'h3f40);
    chk({factory_trim_a, factory_trim_b, factory_trim_c, factory_trim_d,
         emitter_drive}, 34'h0);
  endtask
  task automatic t_data_rw;
    for (int i = 0; i < 5; i++)
      host.wr(8'h7f + 8'(i), 8'ha5 ^ 8'(i));
    for (int i = 0; i < 5; i++)
      rdc(8'h7f + 8'(i), 8'ha5 ^ 8'(i));
  endtask
  task automatic t_entry;
    host.wr_entry(3'h7, E1);
    ent(3'h7, E1);
    look({4'h0, E1[47:0]}, 2'h1, 4'ha, 6'h3d);
    look({4'h3, E1[47:0]}, 2'h3, 4'h0, 6'h3f);
  endtask
  task automatic t_group;
    host.wr_entry(3'h2, E2);
    look({4'h9, E2[47:0]}, 2'h0, 4'h0, 6'h31);
    look({4'h3, E2[47:0]}, 2'h0, 4'h0, 6'h00);
    look({4'h3, E2[47:0]}, 2'h0, 4'hc, 6'h24);
  endtask
  task automatic t_invalid;
    host.wr_entry(3'h2, E3);
    look({4'h9, E3[47:0]}, 2'h0, 4'h0, 6'h00);
    host.wr(8'h83, 8'hff);
    host.wr(8'h79, 8'h04);
    host.wr(8'h7a, 8'h02);
    ent(3'h2, E3);
  endtask
  task automatic t_source;
    @(negedge clk_sys);
    source_station = E1[47:0];
    sa_group = 4'h6;
    sa_req = 1'b1;
    @(negedge clk_sys);
    sa_req = 1'b0;
    source_station = ~E1[47:0];
    chk({fwd_valid, dyn_sa_req, dyn_sa_group, dyn_sa_station},
        {2'b01, 4'h6, E1[47:0]});
  endtask
  // Out-of-range triggers, duplicate match, then a mid-run reset
  task automatic t_range_rst;
    host.wr(8'h79, 8'h01);
    host.wr(8'h7a, 8'h07);
    host.wr(8'h79, 8'h00);
    host.wr(8'h7a, 8'h0f);
    ent(3'h7, E1);
    rdc(8'h79, 8'h10);
    rdc(8'h7a, 8'h07);
    look({4'h0, E1[47:0]}, 2'h2, 4'h0, 6'h3b);
    host.wr_entry(3'h0, {10'h00a, E1[47:0]});
    look({4'h0, E1[47:0]}, 2'h3, 4'h0, 6'h32);
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2)
      @(negedge clk_sys);
    sys_rst = 1'b0;
    ent(3'h7, 58'h0);
    look({4'h0, E1[47:0]}, 2'h2, 4'h0, 6'h00);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever
      #10 clk_sys = ~clk_sys;
  end
  initial
  begin
    sys_rst = 1'b1;
    {da_req, dyn_da_hit, sa_req, da_ingress, dyn_da_ports} = '0;
    {da_station, source_station, da_group, sa_group} = '0;
    repeat (20)
      @(negedge clk_sys);
    sys_rst = 1'b0;
    t_reset_vals();
    t_data_rw();
    t_entry();
    t_group();
    t_invalid();
    t_source();
    t_range_rst();
    summarize();
  end
endmodule // tb
bind smt_static_table smt_checker u_chk (.clk_sys, .sys_rst, .reg_rd,
  .reg_rvalid, .da_req, .dyn_da_hit, .dyn_da_ports, .fwd_valid, .fwd_hit,
  .fwd_static, .fwd_ports, .sa_req, .source_station, .sa_group,
  .dyn_sa_req, .dyn_sa_station, .dyn_sa_group);
